/* verilog/mba_pkg.sv */
// Package of shared constants and types for the multi-master bus arbiter
package mba_pkg;

    // ------------------------------------------------------------
    // Arbiter states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_REQUEST,
        ARB_OWN
    } mba_state_t;

    // ------------------------------------------------------------
    // Values after reset (all active-low lines inactive)
    // ------------------------------------------------------------
    localparam logic RST_BUS_REQUEST_N  = 1'b1;
    localparam logic RST_PRIORITY_OUT_N = 1'b1;
    localparam logic RST_DRIVE_ENABLE_N = 1'b1;
    localparam logic RST_BUSY_PULL      = 1'b0;
    localparam logic RST_COMMON_PULL    = 1'b0;
    localparam logic RST_BUS_CLK_LEVEL  = 1'b1;

endpackage : mba_pkg

/* verilog/mba_link_if.sv */
// Interface carrying sampled bus-side inputs from the sampler to the arbiter core
`timescale 1ns/100ps
`default_nettype none

interface mba_link_if;
    logic busEdge;
    logic priorityIn;
    logic busFree;
    logic commonRequest;

    modport sampler (output busEdge, output priorityIn, output busFree, output commonRequest);
    modport core    (input  busEdge, input  priorityIn, input  busFree, input  commonRequest);
endinterface : mba_link_if

`default_nettype wire

/* verilog/mba_bus_sampler.sv */
// Bus clock falling-edge detector and sampler of bus-side inputs
`timescale 1ns/100ps
`default_nettype none

module mba_bus_sampler
    import mba_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Bus-side pins
    input  wire logic  busClk,
    input  wire logic  priority_in_n,
    input  wire logic  busyIn_n,
    input  wire logic  commonRequestIn_n,
    // To the core
    mba_link_if.sampler link
);

    logic busClkPrev;
    logic next_busClkPrev;

    // ------------------------------------------------------------
    // Falling edge of the bus clock
    // ------------------------------------------------------------
    always_comb begin
        next_busClkPrev = busClk;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busClkPrev <= RST_BUS_CLK_LEVEL;
        end else begin
            busClkPrev <= next_busClkPrev;
        end
    end

    // Bus inputs are synchronous; decisions use them only on this edge
    assign link.busEdge       = busClkPrev & ~busClk;
    assign link.priorityIn    = ~priority_in_n;
    assign link.busFree       = busyIn_n;
    assign link.commonRequest = ~commonRequestIn_n;

endmodule // mba_bus_sampler

`default_nettype wire

/* verilog/mba_arbiter.sv */
// Multi-master bus arbiter: top module
//
// Operation
// - Drive bus request low whenever the system bus is wanted.
// - Priority input low lets the arbiter take the bus at bus clock fall.
// - Loss of priority input means a higher arbiter wins; prepare to surrender.
// - Priority output feeds the next lower arbiter in a daisy chain.
// - With bus free and priority held, seize the bus by pulling busy low.
// - When finished, release busy so it floats high for others.
// - Busy is active-low open drain: only pulled low or released.
// - Hold controller, transceivers and latches off the bus while not owner.
// - After acquiring the bus, release the hold so the stalled cycle proceeds.
// - Never give up the bus in the middle of a transfer cycle.
// - Take the bus whenever no higher master is using it; here it also waits while a lower master pulls busy.
// - Surrender-to-any strap surrenders to lower requesters as to higher ones.
// - With no other requester, keep the bus until the processor halts.
// - Release only when forced by a request or when the processor halts.
// - Drive active-low enable telling controller and latches when to three-state.
// - The owner running a transfer never pulls the common request line.
// - Initialize input low resets the arbiter to not owning the bus.
// - All bus-side signals are acted on at the bus clock edge; here initialize low acts on any system clock edge.
`timescale 1ns/100ps
`default_nettype none

module mba_arbiter
    import mba_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Bus-side inputs
    input  wire logic busClk,
    input  wire logic initialize_n,
    input  wire logic priority_in_n,
    input  wire logic surrender_to_any_strap,
    // Busy line, open drain
    input  wire logic busyIn_n,
    output logic      busyOut,
    output logic      busyOe,
    // Common request line, open drain
    input  wire logic commonRequestIn_n,
    output logic      common_request_nOut,
    output logic      common_request_nOe,
    // Bus-side outputs
    output logic      bus_request_n,
    output logic      priority_out_n,
    // Processor side
    input  wire logic cpuWantsBus,
    input  wire logic cycleActive,
    input  wire logic cpuHalted,
    output logic      drive_enable_n
);

    // Bus-side view; acted on only at a bus clock fall
    mba_link_if link ();

    mba_bus_sampler u_sampler (
        .clk               (clk),
        .rst               (rst),
        .busClk            (busClk),
        .priority_in_n     (priority_in_n),
        .busyIn_n          (busyIn_n),
        .commonRequestIn_n (commonRequestIn_n),
        .link              (link)
    );

    // ------------------------------------------------------------
    // State decoding shared by the output groups
    // ------------------------------------------------------------
    // Owner of the system bus: pulls busy and lets its drivers out
    function automatic logic is_owner(input mba_state_t s);
        logic owner;
        owner = 1'b0;
        unique case (s)
            ARB_IDLE:    owner = 1'b0;
            ARB_REQUEST: owner = 1'b0;
            ARB_OWN:     owner = 1'b1;
        endcase
        return owner;
    endfunction

    // Wanting or holding the bus: request driven, chain grant kept
    function automatic logic is_claiming(input mba_state_t s);
        logic claiming;
        claiming = 1'b0;
        unique case (s)
            ARB_IDLE:    claiming = 1'b0;
            ARB_REQUEST: claiming = 1'b1;
            ARB_OWN:     claiming = 1'b1;
        endcase
        return claiming;
    endfunction

    // Waiting for the bus: the only state that pulls common request
    function automatic logic is_waiting(input mba_state_t s);
        logic waiting;
        waiting = 1'b0;
        unique case (s)
            ARB_IDLE:    waiting = 1'b0;
            ARB_REQUEST: waiting = 1'b1;
            ARB_OWN:     waiting = 1'b0;
        endcase
        return waiting;
    endfunction

    // ------------------------------------------------------------
    // Decision terms, taken only at a bus clock falling edge
    // ------------------------------------------------------------
    logic surrender;
    logic takeEdge;
    logic goRequest;
    logic abandon;
    logic seize;
    logic giveUp;

    // Forced off by priority loss, a processor halt or, with the strap, by any lower requester
    always_comb begin
        surrender = ~link.priorityIn
                  | (surrender_to_any_strap & link.commonRequest)
                  | cpuHalted;
    end

    // No decision is taken between bus clock falls or while initializing
    always_comb begin
        takeEdge = initialize_n & link.busEdge;
    end

    // A halted processor never starts a request for the bus
    always_comb begin
        goRequest = cpuWantsBus & ~cpuHalted;
    end

    // A waiting arbiter whose processor lost interest withdraws
    always_comb begin
        abandon = ~cpuWantsBus;
    end

    // Priority held and busy released by every other master
    always_comb begin
        seize = cpuWantsBus & link.priorityIn & link.busFree;
    end

    // A started transfer cycle is never cut short
    always_comb begin
        giveUp = surrender & ~cycleActive;
    end

    // ------------------------------------------------------------
    // Arbitration state
    // ------------------------------------------------------------
    mba_state_t state;
    mba_state_t next_state;

    always_comb begin
        next_state = state;
        if (!initialize_n) begin
            next_state = ARB_IDLE;
        end else if (takeEdge) begin
            unique case (state)
                ARB_IDLE: begin
                    if (goRequest) begin
                        next_state = ARB_REQUEST;
                    end else begin
                        next_state = ARB_IDLE;
                    end
                end
                // Withdrawal wins over a grant seen at the same edge
                ARB_REQUEST: begin
                    if (abandon) begin
                        next_state = ARB_IDLE;
                    end else if (seize) begin
                        next_state = ARB_OWN;
                    end else begin
                        next_state = ARB_REQUEST;
                    end
                end
                // Kept between cycles until forced off or halted
                ARB_OWN: begin
                    if (giveUp) begin
                        next_state = ARB_IDLE;
                    end else begin
                        next_state = ARB_OWN;
                    end
                end
                // Unused code falls back to idle
                default: begin
                    next_state = ARB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ARB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Open-drain pulls on the busy and common request lines
    // ------------------------------------------------------------
    logic busyPull;
    logic next_busyPull;
    logic commonPull;
    logic next_commonPull;

    // The owner leaves the common request line to lower requesters
    always_comb begin
        next_busyPull   = busyPull;
        next_commonPull = commonPull;
        if (!initialize_n) begin
            next_busyPull   = RST_BUSY_PULL;
            next_commonPull = RST_COMMON_PULL;
        end else if (takeEdge) begin
            next_busyPull   = is_owner(next_state);
            next_commonPull = is_waiting(next_state);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busyPull   <= RST_BUSY_PULL;
            commonPull <= RST_COMMON_PULL;
        end else begin
            busyPull   <= next_busyPull;
            commonPull <= next_commonPull;
        end
    end

    // ------------------------------------------------------------
    // Request and daisy-chain priority outputs
    // ------------------------------------------------------------
    logic requestOut_n;
    logic next_requestOut_n;
    logic prioOut_n;
    logic next_prioOut_n;

    // An idle arbiter passes the chain grant on; a claiming one keeps it
    always_comb begin
        next_requestOut_n = requestOut_n;
        next_prioOut_n    = prioOut_n;
        if (!initialize_n) begin
            next_requestOut_n = RST_BUS_REQUEST_N;
            next_prioOut_n    = RST_PRIORITY_OUT_N;
        end else if (takeEdge) begin
            next_requestOut_n = ~is_claiming(next_state);
            next_prioOut_n    = is_claiming(next_state) | priority_in_n;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            requestOut_n <= RST_BUS_REQUEST_N;
            prioOut_n    <= RST_PRIORITY_OUT_N;
        end else begin
            requestOut_n <= next_requestOut_n;
            prioOut_n    <= next_prioOut_n;
        end
    end

    // ------------------------------------------------------------
    // Hold on the local controller, latches and transceivers
    // ------------------------------------------------------------
    logic enableOut_n;
    logic next_enableOut_n;

    // Drivers stay three-stated until this arbiter pulls busy itself
    always_comb begin
        next_enableOut_n = enableOut_n;
        if (!initialize_n) begin
            next_enableOut_n = RST_DRIVE_ENABLE_N;
        end else if (takeEdge) begin
            next_enableOut_n = ~is_owner(next_state);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enableOut_n <= RST_DRIVE_ENABLE_N;
        end else begin
            enableOut_n <= next_enableOut_n;
        end
    end

    // ------------------------------------------------------------
    // Open-drain lines: data always low, enable while pulling
    // ------------------------------------------------------------
    assign busyOut             = 1'b0;
    assign busyOe              = busyPull;
    assign common_request_nOut = 1'b0;
    assign common_request_nOe  = commonPull;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    assign bus_request_n  = requestOut_n;
    assign priority_out_n = prioOut_n;
    assign drive_enable_n = enableOut_n;

endmodule // mba_arbiter

`default_nettype wire

/* tb/mba_far_side.sv */
// Far-side model: bus clock, other arbiters and priority resolver
`timescale 1ns/100ps
`default_nettype none
module mba_far_side (
    // Clock, reset and scenario controls
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic higherReq,
    input  wire logic lowerReq,
    input  wire logic otherBusy,
    input  wire logic chainMode,
    // Arbiter side
    input  wire logic busyOe,
    input  wire logic busyOut,
    input  wire logic commonOe,
    input  wire logic commonOut,
    input  wire logic bus_request_n,
    output wire logic busClk,
    output logic      priority_in_n,
    output wire logic busyIn_n,
    output wire logic commonRequestIn_n
);
    logic [1:0] phase;
    // ----------------------------------------
    // Bus clock, four system clocks a period
    // ----------------------------------------
    assign busClk = ~phase[1];
    always @(negedge clk or posedge rst)
        if (rst) phase <= 2'h0;
        else phase <= phase + 2'h1;
    // Grant only the highest requester; chain mode passes grant when idle
    always @(negedge clk or posedge rst)
        if (rst) priority_in_n <= 1'b1;
        else priority_in_n <= higherReq | (bus_request_n & ~chainMode);
    // Pull-ups on both shared lines
    assign busyIn_n = ~((busyOe & ~busyOut) | otherBusy);
    assign commonRequestIn_n = ~((commonOe & ~commonOut) | lowerReq);
endmodule // mba_far_side
`default_nettype wire

/* tb/mba_arbiter_chk.sv */
// Port assertions for the bus arbiter
`timescale 1ns/100ps
`default_nettype none
module mba_arbiter_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Arbiter ports
    input wire logic busClk,
    input wire logic initialize_n,
    input wire logic priority_in_n,
    input wire logic surrender_to_any_strap,
    input wire logic busyIn_n,
    input wire logic busyOe,
    input wire logic commonRequestIn_n,
    input wire logic common_request_nOe,
    input wire logic bus_request_n,
    input wire logic priority_out_n,
    input wire logic cpuWantsBus,
    input wire logic cycleActive,
    input wire logic cpuHalted,
    input wire logic drive_enable_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] fellHist;
    always_ff @(posedge clk or posedge rst)
        if (rst) fellHist <= 2'h0;
        else fellHist <= {fellHist[0], $fell(busClk)};
    sequence s_granted;
        !bus_request_n && !priority_in_n && busyIn_n && cpuWantsBus && initialize_n && !cpuHalted;
    endsequence
    AST_SYNC_EDGE: assert property (!$stable({bus_request_n, drive_enable_n, busyOe})
        |-> (|fellHist) || !$past(initialize_n) || $past(rst) || $past(rst, 2)) else $error("Off edge");
    AST_HOLD_OFF: assert property (drive_enable_n == !busyOe)
        else $error("Enable and busy disagree");
    AST_OWNER_QUIET: assert property (busyOe |-> !common_request_nOe)
        else $error("Owner pulls common request");
    AST_SEIZE: assert property ($rose(busyOe) |-> $past(!bus_request_n)
        && (!$past(priority_in_n) || !$past(priority_in_n, 2))) else $error("Seized without grant");
    AST_GRANT: assert property (s_granted [*3] |-> ##[0:8] busyOe)
        else $error("Grant not taken");
    AST_MID_CYCLE: assert property ($fell(busyOe) && $past(initialize_n) |-> !$past(cycleActive))
        else $error("Released mid cycle");
    AST_NO_VOLUNTARY: assert property ($fell(busyOe) && $past(initialize_n) |->
        $past(priority_in_n) || $past(priority_in_n, 2) || $past(cpuHalted) ||
        ($past(surrender_to_any_strap) && !$past(commonRequestIn_n))) else $error("Voluntary release");
    AST_REQ_DROP: assert property ($fell(busyOe) |-> bus_request_n)
        else $error("Request kept after release");
    AST_PRIO_OUT: assert property (!bus_request_n |-> priority_out_n)
        else $error("Priority passed while requesting");
    AST_INIT: assert property (!initialize_n |=> bus_request_n && !busyOe)
        else $error("Init did not clear");
endmodule // mba_arbiter_chk
bind mba_arbiter mba_arbiter_chk chk_u (.clk, .rst, .busClk, .initialize_n, .priority_in_n,
    .surrender_to_any_strap, .busyIn_n, .busyOe, .commonRequestIn_n, .common_request_nOe,
    .bus_request_n, .priority_out_n, .cpuWantsBus, .cycleActive, .cpuHalted, .drive_enable_n);
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the bus arbiter
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic      clk, rst, initialize_n, surrender_to_any_strap, cpuWantsBus, cycleActive, cpuHalted;
    logic      higherReq, lowerReq, otherBusy, chainMode, busyOut, busyOe, drive_enable_n;
    logic      common_request_nOut, common_request_nOe, bus_request_n, priority_out_n;
    wire logic busClk, priority_in_n, busyIn_n, commonRequestIn_n;
    int        errors = 0;
    int        total_checks = 0;
    mba_arbiter dut_u (.clk, .rst, .busClk, .initialize_n, .priority_in_n,
        .surrender_to_any_strap, .busyIn_n, .busyOut, .busyOe, .commonRequestIn_n,
        .common_request_nOut, .common_request_nOe, .bus_request_n, .priority_out_n,
        .cpuWantsBus, .cycleActive, .cpuHalted, .drive_enable_n);
    mba_far_side far_u (.clk, .rst, .higherReq, .lowerReq, .otherBusy, .chainMode, .busyOe,
        .busyOut, .commonOe(common_request_nOe), .commonOut(common_request_nOut),
        .bus_request_n, .busClk, .priority_in_n, .busyIn_n, .commonRequestIn_n);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize();
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic await_own(input logic v);
        int n;
        n = 0;
        while (busyOe !== v && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (busyOe !== v) begin
            check(busyOe, v);
            summarize();
        end
    endtask
    task automatic hold_then(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic surrender_rules();
        cpuWantsBus = 1'b1;
        await_own(1'b1);
        check(bus_request_n, 1'b0);
        check(drive_enable_n, 1'b0);
        check(common_request_nOe, 1'b0);
        check(busyOut, 1'b0);
        check(common_request_nOut, 1'b0);
        cpuWantsBus = 1'b0;
        lowerReq = 1'b1;
        hold_then(40);
        check(busyOe, 1'b1);
        surrender_to_any_strap = 1'b1;
        await_own(1'b0);
        check(bus_request_n, 1'b1);
        {lowerReq, surrender_to_any_strap} = 2'h0;
    endtask
    task automatic preempt_and_wait();
        cpuWantsBus = 1'b1;
        await_own(1'b1);
        {cycleActive, higherReq} = 2'h3;
        hold_then(40);
        check(busyOe, 1'b1);
        cycleActive = 1'b0;
        await_own(1'b0);
        check(drive_enable_n, 1'b1);
        check(busyIn_n, 1'b1);
        otherBusy = 1'b1;
        higherReq = 1'b0;
        hold_then(40);
        check(busyOe, 1'b0);
        check(common_request_nOe, 1'b1);
        check(bus_request_n, 1'b0);
        otherBusy = 1'b0;
        await_own(1'b1);
    endtask
    task automatic halt_and_init();
        cpuHalted = 1'b1;
        await_own(1'b0);
        hold_then(20);
        check(bus_request_n, 1'b1);
        cpuHalted = 1'b0;
        await_own(1'b1);
        initialize_n = 1'b0;
        hold_then(2);
        check(busyOe, 1'b0);
        check(drive_enable_n, 1'b1);
        {initialize_n, cpuWantsBus, chainMode} = 3'h5;
        hold_then(20);
        check(priority_out_n, 1'b0);
        higherReq = 1'b1;
        hold_then(20);
        check(priority_out_n, 1'b1);
    endtask
    initial begin
        {rst, initialize_n, surrender_to_any_strap, cpuWantsBus, cycleActive, cpuHalted} = 6'h30;
        {higherReq, lowerReq, otherBusy, chainMode} = 4'h0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        hold_then(2);
        check(bus_request_n, 1'b1);
        check(drive_enable_n, 1'b1);
        surrender_rules();
        preempt_and_wait();
        halt_and_init();
        summarize();
    end
endmodule // testbench
`default_nettype wire
